// ### design/synth_port_map.svh
`ifndef SYNTH_PORT_MAP_SVH
`define SYNTH_PORT_MAP_SVH

// serial word layout
`define WORD_W          24
`define SEL_W           2
`define SEL_MSB         1
`define SEL_LSB         0
`define SEL_CONTROL     2'h0
`define SEL_REF_DIV     2'h1
`define SEL_FB_DIV      2'h2
`define SEL_TEST        2'h3
`define LATCH_COUNT     4

// control latch fields
`define MON_SEL_MSB     7
`define MON_SEL_LSB     5
`define MON_SEL_W       3
`define MON_SEL_RESET   3'h0
`define MON_LOCK        3'h1
`define MON_RF_DIV      3'h2
`define MON_REF_DIV     3'h4
`define PD_BIT          3

// register map, byte addresses
`define ADDR_W          5
`define ADDR_IDX_MSB    4
`define ADDR_IDX_LSB    2
`define IDX_W           3
`define IDX_CONTROL     3'h0
`define IDX_REF_DIV     3'h1
`define IDX_FB_DIV      3'h2
`define IDX_TEST        3'h3
`define IDX_STATUS      3'h4
`define IDX_CONFIG      3'h5

// status and config fields
`define ST_CHIP_POWER   0
`define ST_POWERED_DOWN 1
`define ST_LAST_SEL_LSB 8
`define ST_COUNT_LSB    16
`define COUNT_W         16
`define CFG_MON_EN      0
`define CONFIG_RESET    32'h0000_0001

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### design/synth_port_pkg.sv
package synth_port_pkg;

    // read channel sequencing
    typedef enum logic [1:0] {
        rd_idle,
        rd_fetch,
        rd_load,
        rd_resp
    } rd_state_type;

endpackage : synth_port_pkg

// ### design/latch_bank.sv
`timescale 1ns/1ps
`include "synth_port_map.svh"

module latch_bank #(
    parameter int WIDTH = `WORD_W,
    parameter int DEPTH = `LATCH_COUNT
) (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     clk_en,
    // write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    // read port
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);

    if (DEPTH < 2 || WIDTH < 1) begin : g_check
        $error("latch_bank needs at least two words of one bit");
    end

    logic [WIDTH-1:0] words [DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // only the addressed word changes, the others keep their contents
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                words[i] <= '0;
            end
            rd_data <= '0;
        end else if (clk_en) begin
            if (wr_en) begin
                words[wr_addr] <= wr_data;
            end
            rd_data <= words[rd_addr];    // registered read
        end
    end

endmodule : latch_bank

// ### design/synth_serial_load_port.sv
// Functional notes
// - each serial clock rising edge shifts the data pin into a 24-bit register.
// - two lowest word bits select the destination latch, not payload.
// - load strobe rise copies the word into the selected latch only.
// - monitor output shows lock detect, divided feedback or divided reference.
// - chip power low forces the powered-down state whatever is programmed.
// - chip power low three-states the charge pump output.
// - chip power high powers up only if programmed power-down bit allows.
// - select codes 00 control, 01 reference, 10 feedback, 11 test latch.
// - a three-bit field in the control latch picks the monitor signal.
`timescale 1ns/1ps
`include "synth_port_map.svh"

module synth_serial_load_port #(
    parameter int WORD_W = `WORD_W
) (
    // system clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // serial programming pins
    input  wire logic        serial_clock,
    input  wire logic        serial_data,
    input  wire logic        load_strobe,
    // chip power pin
    input  wire logic        chip_power,
    // internal monitor sources, asynchronous
    input  wire logic        lock_detect,
    input  wire logic        rf_divided,
    input  wire logic        ref_divided,
    // pump drive from loop logic on aclk
    input  wire logic        pump_level,
    // pins out
    output logic             monitor_output,
    output logic             charge_pump_output,
    output logic             charge_pump_output_oe,
    output logic             powered_down
);

    if (WORD_W != `WORD_W) begin : g_check
        $error("serial word width must match the register map");
    end

    // bus index of a byte address
    function automatic logic [`IDX_W-1:0] reg_index(input logic [31:0] addr);
        reg_index = addr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
    endfunction : reg_index

    // true for addresses inside the mapped window
    function automatic logic reg_mapped(input logic [31:0] addr);
        reg_mapped = (addr[31:`ADDR_W] == '0) && (reg_index(addr) <= `IDX_CONFIG);
    endfunction : reg_mapped

    ////////////////////////////////////////////////////////////////////////////
    // link domain: shift register on the serial clock
    logic [WORD_W-1:0] shift_word;
    logic [WORD_W-1:0] next_shift_word;

    // oldest bit falls off the top, so only the newest bits survive
    always_comb begin
        next_shift_word = {shift_word[WORD_W-2:0], serial_data};
    end

    // no reset pin exists; the word is data, framed by the load strobe
    always_ff @(posedge serial_clock) begin
        shift_word <= next_shift_word;
    end

    ////////////////////////////////////////////////////////////////////////////
    // crossings into aclk: two flops for each pin and for the held word, a third on the strobe for its edge
    logic              strobe_s1;
    logic              strobe_s2;
    logic              strobe_s3;
    logic              power_s1;
    logic              power_s2;
    logic [2:0]        mon_src_s1;
    logic [2:0]        mon_src_s2;
    logic [WORD_W-1:0] word_s1;
    logic [WORD_W-1:0] word_s2;

    // the word is quiet while the strobe is high, so it crosses as a level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_s1  <= 1'b0;
            strobe_s2  <= 1'b0;
            strobe_s3  <= 1'b0;
            power_s1   <= 1'b0;
            power_s2   <= 1'b0;
            mon_src_s1 <= 3'h0;
            mon_src_s2 <= 3'h0;
            word_s1    <= '0;
            word_s2    <= '0;
        end else if (clk_en) begin
            strobe_s1  <= load_strobe;
            strobe_s2  <= strobe_s1;
            strobe_s3  <= strobe_s2;
            power_s1   <= chip_power;
            power_s2   <= power_s1;
            mon_src_s1 <= {ref_divided, rf_divided, lock_detect};
            mon_src_s2 <= mon_src_s1;
            word_s1    <= shift_word;
            word_s2    <= word_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // load path: strobe rise writes one latch
    logic                  load_now;
    logic [`SEL_W-1:0]     load_sel;
    logic [`MON_SEL_W-1:0] mon_sel;
    logic [`MON_SEL_W-1:0] next_mon_sel;
    logic                  pd_prog;
    logic                  next_pd_prog;
    logic [`SEL_W-1:0]     last_sel;
    logic [`SEL_W-1:0]     next_last_sel;
    logic [`COUNT_W-1:0]   load_count;
    logic [`COUNT_W-1:0]   next_load_count;

    assign load_now = strobe_s2 & ~strobe_s3;
    assign load_sel = word_s2[`SEL_MSB:`SEL_LSB];

    // shadow the control latch fields the block itself needs every cycle
    always_comb begin
        next_mon_sel    = mon_sel;
        next_pd_prog    = pd_prog;
        next_last_sel   = last_sel;
        next_load_count = load_count;
        if (load_now) begin
            next_last_sel   = load_sel;
            next_load_count = load_count + 1'b1;
            if (load_sel == `SEL_CONTROL) begin
                next_mon_sel = word_s2[`MON_SEL_MSB:`MON_SEL_LSB];
                next_pd_prog = word_s2[`PD_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_sel    <= `MON_SEL_RESET;
            pd_prog    <= 1'b0;
            last_sel   <= `SEL_CONTROL;
            load_count <= '0;
        end else if (clk_en) begin
            mon_sel    <= next_mon_sel;
            pd_prog    <= next_pd_prog;
            last_sel   <= next_last_sel;
            load_count <= next_load_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // the four latches
    logic [1:0]        bank_rd_addr;
    logic [WORD_W-1:0] bank_rd_data;

    latch_bank #(
        .WIDTH (WORD_W),
        .DEPTH (`LATCH_COUNT)
    ) u_latches (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_en  (clk_en),
        .wr_en   (load_now),
        .wr_addr (load_sel),
        .wr_data (word_s2),
        .rd_addr (bank_rd_addr),
        .rd_data (bank_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pins: power state, charge pump and monitor
    logic [31:0] config_reg;
    logic        next_powered_down;
    logic        next_monitor;

    // pin low always wins over the programmed bit
    always_comb begin
        next_powered_down = ~power_s2 | pd_prog;
        next_monitor      = 1'b0;
        case (mon_sel)
            `MON_LOCK:    next_monitor = mon_src_s2[0];
            `MON_RF_DIV:  next_monitor = mon_src_s2[1];
            `MON_REF_DIV: next_monitor = mon_src_s2[2];
            default:      next_monitor = 1'b0;
        endcase
        if (!config_reg[`CFG_MON_EN]) begin
            next_monitor = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            powered_down          <= 1'b1;
            charge_pump_output    <= 1'b0;
            charge_pump_output_oe <= 1'b0;
            monitor_output        <= 1'b0;
        end else if (clk_en) begin
            powered_down          <= next_powered_down;
            charge_pump_output    <= pump_level;
            charge_pump_output_oe <= ~next_powered_down;
            monitor_output        <= next_monitor;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus write side: address and data may arrive in either order
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic        next_w_held;
    logic [31:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic [31:0] next_config;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

    // only the config word is writable; latches are loaded from the pins
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_config  = config_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `RESP_SLVERR;
            if (reg_mapped(aw_addr) && reg_index(aw_addr) == `IDX_CONFIG) begin
                next_bresp = `RESP_OKAY;
                for (int b = 0; b < 4; b++) begin
                    if (w_strb[b]) begin
                        next_config[b*8 +: 8] = w_data[b*8 +: 8];
                    end
                end
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= '0;
            w_data       <= '0;
            w_strb       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            config_reg   <= `CONFIG_RESET;
        end else if (clk_en) begin
            aw_held      <= next_aw_held;
            w_held       <= next_w_held;
            aw_addr      <= next_aw_addr;
            w_data       <= next_w_data;
            w_strb       <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            config_reg   <= next_config;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus read side: one spare cycle lets the latch bank register its word
    synth_port_pkg::rd_state_type rd_state;
    synth_port_pkg::rd_state_type next_rd_state;
    logic [31:0]                  ar_addr;
    logic [31:0]                  next_ar_addr;
    logic [31:0]                  next_rdata;
    logic [1:0]                   next_rresp;
    logic [31:0]                  status_word;

    assign s_axi_arready = (rd_state == synth_port_pkg::rd_idle);
    assign s_axi_rvalid  = (rd_state == synth_port_pkg::rd_resp);
    assign bank_rd_addr  = ar_addr[`ADDR_IDX_LSB+1:`ADDR_IDX_LSB];

    always_comb begin
        status_word                        = '0;
        status_word[`ST_CHIP_POWER]        = power_s2;
        status_word[`ST_POWERED_DOWN]      = powered_down;
        status_word[`ST_LAST_SEL_LSB +: 2] = last_sel;
        status_word[`ST_COUNT_LSB +: 16]   = load_count;
    end

    always_comb begin
        next_rd_state = rd_state;
        next_ar_addr  = ar_addr;
        next_rdata    = s_axi_rdata;
        next_rresp    = s_axi_rresp;
        case (rd_state)
            synth_port_pkg::rd_idle: begin
                if (s_axi_arvalid) begin
                    next_ar_addr  = s_axi_araddr;
                    next_rd_state = synth_port_pkg::rd_fetch;
                end
            end
            synth_port_pkg::rd_fetch: begin
                next_rd_state = synth_port_pkg::rd_load;
            end
            synth_port_pkg::rd_load: begin
                next_rresp = `RESP_OKAY;
                next_rdata = '0;
                if (!reg_mapped(ar_addr)) begin
                    next_rresp = `RESP_SLVERR;
                end else if (reg_index(ar_addr) == `IDX_STATUS) begin
                    next_rdata = status_word;
                end else if (reg_index(ar_addr) == `IDX_CONFIG) begin
                    next_rdata = config_reg;
                end else begin
                    next_rdata = {8'h00, bank_rd_data};
                end
                next_rd_state = synth_port_pkg::rd_resp;
            end
            synth_port_pkg::rd_resp: begin
                if (s_axi_rready) begin
                    next_rd_state = synth_port_pkg::rd_idle;
                end
            end
            default: begin
                next_rd_state = synth_port_pkg::rd_idle;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state    <= synth_port_pkg::rd_idle;
            ar_addr     <= '0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (clk_en) begin
            rd_state    <= next_rd_state;
            ar_addr     <= next_ar_addr;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule : synth_serial_load_port

// ### dv/serial_controller.sv
`timescale 1ns/1ps
// host side of the three-wire port
module serial_controller (
    // serial pins
    output logic serial_clock = 1'b0,
    output logic serial_data  = 1'b0,
    output logic load_strobe  = 1'b0
);
    ////////////////////////////////////////
    // one frame at 32 ns a bit; the clock parks low between frames
    // the caller puts the latch code in the two lowest bits
    task automatic send(input logic [31:0] w, input int nbits, input bit load, input int gap);
        #(gap);
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_data = w[i];
            #16 serial_clock = 1'b1;
            #16 serial_clock = 1'b0;
        end
        // released line shows the inverse so no stale bit looks valid
        serial_data = ~serial_data;
        if (load) begin
            #20 load_strobe = 1'b1;
            #200 load_strobe = 1'b0;     // longer than three system cycles
        end
    endtask : send
endmodule : serial_controller

// ### dv/port_rules_sva.sv
`timescale 1ns/1ps
// bus and pin relations at the ports
module port_rules_sva #(
    parameter int WORD_W = 24
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    // bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // power and pump pins
    input wire logic        chip_power,
    input wire logic        pump_level,
    input wire logic        charge_pump_output,
    input wire logic        charge_pump_output_oe,
    input wire logic        powered_down
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    // write address and data in one edge, read address taken
    sequence aw_w_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////
    write_answer_a:
        assert property (aw_w_take |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("late write response");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    write_busy_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write open too early");
    read_answer_a:
        assert property (ar_take |=> !s_axi_rvalid [*2] ##1 s_axi_rvalid) else $error("late read data");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    read_busy_a:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read address open too early");
    // three edges of synchroniser and register before power-down shows
    power_low_a:
        assert property ((!chip_power && clk_en) [*4] |-> powered_down) else $error("not powered down");
    pump_float_a:
        assert property (charge_pump_output_oe == !powered_down) else $error("pump driven while down");
    pump_pass_a:
        assert property (clk_en |=> charge_pump_output == $past(pump_level)) else $error("pump level lost");
endmodule : port_rules_sva

bind synth_serial_load_port port_rules_sva #(.WORD_W(WORD_W)) i_port_rules_sva (.*);

// ### dv/synth_serial_load_port_test.sv
`timescale 1ns/1ps
`include "synth_port_map.svh"
// bench with a model of latches and status
module synth_serial_load_port_test;
    logic        aclk;
    logic        aresetn = 1'b0, clk_en = 1'b1, chip_power = 1'b0, pump_level = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        lock_detect = 1'b0, rf_divided = 1'b0, ref_divided = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, r;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, sclk, sdata, lstrobe, mon, cp_out, cp_oe, pdown;
    logic [23:0] latch_m [4] = '{default: 24'h0};
    logic [15:0] loads = 16'h0;
    logic [1:0]  last_sel = 2'h0;
    logic [31:0] cfg_m = 32'h1;
    logic [2:0]  codes [5] = '{`MON_RF_DIV, `MON_REF_DIV, 3'h0, 3'h6, `MON_LOCK};
    integer      seed = 32'h3c870fb5;
    int          err_count = 0, checks = 0;

    serial_controller host (.serial_clock(sclk), .serial_data(sdata), .load_strobe(lstrobe));
    synth_serial_load_port i_synth_serial_load_port (
        .aclk, .aresetn, .clk_en, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_clock(sclk),
        .serial_data(sdata), .load_strobe(lstrobe), .chip_power, .lock_detect,
        .rf_divided, .ref_divided, .pump_level,
        .monitor_output(mon), .charge_pump_output(cp_out), .charge_pump_output_oe(cp_oe),
        .powered_down(pdown)
    );
    ////////////////////////////////////////
    // clock and a random pump level
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) pump_level <= 1'($random(seed));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    function automatic logic [31:0] status_exp();
        return {loads, 6'h0, last_sel, 6'h0, !chip_power || latch_m[0][`PD_BIT], chip_power};
    endfunction : status_exp

    function automatic logic mon_exp();
        case (latch_m[0][`MON_SEL_MSB:`MON_SEL_LSB])
            `MON_LOCK:    return lock_detect & cfg_m[0];
            `MON_RF_DIV:  return rf_divided & cfg_m[0];
            `MON_REF_DIV: return ref_divided & cfg_m[0];
            default:      return 1'b0;
        endcase
    endfunction : mon_exp

    function automatic logic [31:0] ctrl_word(input logic [2:0] m, input logic pd, input logic [31:0] x);
        return {x[31:8], m, x[4], pd, x[2], `SEL_CONTROL};
    endfunction : ctrl_word
    ////////////////////////////////////////
    // ready rises only after the answer shows, so the slave must hold it
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit done = 1'b0;
        @(posedge aclk);
        {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, s, 2'b11};
        while (!done) begin
            @(posedge aclk);
            if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1 && bready === 1'b1) begin
                check("bresp", bresp, er);
                bready <= 1'b0;
                done = 1'b1;
            end else if (bvalid === 1'b1) bready <= 1'b1;
        end
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [1:0] er, input logic [31:0] ed);
        bit done = 1'b0;
        @(posedge aclk);
        {araddr, arvalid} <= {a, 1'b1};
        while (!done) begin
            @(posedge aclk);
            if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1 && rready === 1'b1) begin
                check("rresp", rresp, er);
                check("rdata", rdata, ed);
                rready <= 1'b0;
                done = 1'b1;
            end else if (rvalid === 1'b1) rready <= 1'b1;
        end
    endtask : rd

    task automatic check_all();
        for (int i = 0; i < 4; i++) rd(32'(i * 4), `RESP_OKAY, {8'h0, latch_m[i]});
        rd(32'h10, `RESP_OKAY, status_exp());
        rd(32'h14, `RESP_OKAY, cfg_m);
    endtask : check_all

    // one host frame, then the model; the gap varies the pace
    task automatic prog(input logic [31:0] w, input int nbits, input bit load);
        @(posedge aclk);
        host.send(w, nbits, load, 7 + 40 * int'(loads[1:0]));
        if (load) begin
            latch_m[w[1:0]] = w[23:0];
            loads++;
            last_sel = w[1:0];
        end
        repeat (10) @(posedge aclk);
    endtask : prog
    ////////////////////////////////////////
    initial begin
        #1ms;
        err_count++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        check("powered_down", pdown, 1'b1);
        check_all();
        // reference, control, feedback in power-up order
        r = $random(seed);
        prog({r[31:2], `SEL_REF_DIV}, 24, 1'b1);
        check_all();
        prog(ctrl_word(`MON_LOCK, 1'b0, r), 24, 1'b1);
        prog({r[31:2], `SEL_FB_DIV}, 24, 1'b1);
        check_all();
        chip_power <= 1'b1;
        repeat (5) @(posedge aclk);
        check("powered_down", pdown, 1'b0);
        check("pump_enable", cp_oe, 1'b1);
        // five monitor codes, the three sources and two unused codes, against random source levels
        foreach (codes[i]) begin
            prog(ctrl_word(codes[i], 1'b0, $random(seed)), 24, 1'b1);
            repeat (3) begin
                r = $random(seed);
                {lock_detect, rf_divided, ref_divided} <= r[2:0];
                repeat (6) @(posedge aclk);
                check("monitor_output", mon, mon_exp());
            end
        end
        lock_detect <= 1'b1;
        wr(32'h14, 32'h0, 4'hf, `RESP_OKAY);
        cfg_m = 32'h0;
        repeat (6) @(posedge aclk);
        check("monitor_output", mon, mon_exp());
        wr(32'h14, 32'h1, 4'h2, `RESP_OKAY); // strobe misses the enable byte
        rd(32'h14, `RESP_OKAY, cfg_m);
        wr(32'h14, 32'h1, 4'h1, `RESP_OKAY);
        cfg_m = 32'h1;
        // power-down bit, then the pin
        prog(ctrl_word(`MON_LOCK, 1'b1, r), 24, 1'b1);
        check("powered_down", pdown, 1'b1);
        prog(ctrl_word(`MON_LOCK, 1'b0, r), 24, 1'b1);
        clk_en <= 1'b0;
        chip_power <= 1'b0;
        repeat (5) @(posedge aclk);
        check("frozen", pdown, 1'b0);
        clk_en <= 1'b1;
        repeat (5) @(posedge aclk);
        check("powered_down", pdown, 1'b1);
        check("pump_enable", cp_oe, 1'b0);
        check_all();
        chip_power <= 1'b1;
        // long frame keeps the newest bits; no strobe, no change
        prog({r[31:2], `SEL_FB_DIV}, 30, 1'b1);
        prog($random(seed), 24, 1'b0);
        check_all();
        // refused accesses change nothing
        wr(32'h0, 32'h0, 4'hf, `RESP_SLVERR);
        wr(32'h1c, 32'h0, 4'hf, `RESP_SLVERR);
        rd(32'h18, `RESP_SLVERR, 32'h0);
        check_all();
        // random words to the user latches only
        repeat (8) begin
            r = $random(seed);
            prog({r[31:2], 2'(r[1:0] % 3)}, 24, 1'b1);
            check_all();
        end
        conclude();
    end
endmodule : synth_serial_load_port_test
